// File: rtl/apr_pkg.sv
// package of offsets, fields, resets, codes and timing for the accel power/range bank
package apr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FULL_SCALE = 8'h0F;
  localparam logic [7:0] IDX_BANDWIDTH = 8'h10;
  localparam logic [7:0] IDX_POWER_STATE = 8'h11;
  localparam logic [7:0] IDX_LOW_POWER = 8'h12;
  // reset values
  localparam logic [7:0] RST_FULL_SCALE = 8'h03;
  localparam logic [7:0] RST_BANDWIDTH = 8'h0F;
  localparam logic [7:0] RST_POWER_STATE = 8'h00;
  localparam logic [7:0] RST_LOW_POWER = 8'h00;
  // writable bit masks, reserved bits read zero
  localparam logic [7:0] MASK_FULL_SCALE = 8'h0F;
  localparam logic [7:0] MASK_BANDWIDTH = 8'h1F;
  localparam logic [7:0] MASK_POWER_STATE = 8'hFE;
  localparam logic [7:0] MASK_LOW_POWER = 8'h60;
  // field positions
  localparam int POS_SUSPEND = 7;
  localparam int POS_LOWPOWER = 6;
  localparam int POS_DEEP = 5;
  localparam int POS_SLEEP_LSB = 1;
  localparam int POS_VARIANT = 6;
  localparam int POS_TIMEBASE = 5;
  // range codes
  localparam logic [3:0] RANGE_2G = 4'h3;
  localparam logic [3:0] RANGE_4G = 4'h5;
  localparam logic [3:0] RANGE_8G = 4'h8;
  localparam logic [3:0] RANGE_16G = 4'hC;
  // bandwidth window, codes outside clamp to the ends
  localparam logic [4:0] BW_LOW_CODE = 5'h08;
  localparam logic [4:0] BW_HIGH_CODE = 5'h0F;
  // lean-variant write pacing in time and cycles at 200 MHz
  localparam int CLOCK_MHZ = 200;
  localparam int LEAN_WRITE_GAP_NS = 450;
  localparam int LEAN_WRITE_GAP_CYC = (LEAN_WRITE_GAP_NS * CLOCK_MHZ + 999) / 1000;
  // decoded full-scale select
  typedef enum logic [2:0] {
    APR_FS_2G = 3'b000,
    APR_FS_4G = 3'b001,
    APR_FS_8G = 3'b011,
    APR_FS_16G = 3'b010,
    APR_FS_RSVD = 3'b110
  } apr_fs_t;
  // main power state
  typedef enum logic [2:0] {
    APR_PWR_NORMAL = 3'b000,
    APR_PWR_LOW = 3'b001,
    APR_PWR_SUSPEND = 3'b011,
    APR_PWR_DEEP = 3'b010,
    APR_PWR_ILLEGAL = 3'b110
  } apr_pwr_t;
endpackage

// File: rtl/apr_decode.sv
// decoder turning stored settings into range, bandwidth and power selections
`timescale 1ns/1ps
`default_nettype none
module apr_decode
  import apr_pkg::*;
(
  input wire logic [7:0] full_scale_reg, // stored full-scale register
  input wire logic [7:0] bandwidth_reg, // stored bandwidth register
  input wire logic [7:0] power_reg, // stored power register
  output apr_pkg::apr_fs_t fs_sel, // decoded full scale
  output logic [2:0] bw_index, // 0 is 7.81 Hz .. 7 is 1000 Hz
  output apr_pkg::apr_pwr_t pwr_sel // decoded power state
);
  import apr_pkg::*;
  wire logic [3:0] range_code = full_scale_reg[3:0];
  wire logic [4:0] filter_band_code = bandwidth_reg[4:0];
  wire logic [2:0] pwr_bits = {power_reg[POS_SUSPEND], power_reg[POS_LOWPOWER], power_reg[POS_DEEP]};
  // range code to full scale
  assign fs_sel = (range_code == RANGE_2G) ? APR_FS_2G :
                  (range_code == RANGE_4G) ? APR_FS_4G :
                  (range_code == RANGE_8G) ? APR_FS_8G :
                  (range_code == RANGE_16G) ? APR_FS_16G : APR_FS_RSVD;
  // bandwidth with clamping at both ends
  assign bw_index = filter_band_code[4] ? 3'h7 :
                    (filter_band_code < BW_LOW_CODE) ? 3'h0 :
                    filter_band_code[2:0];
  // {suspend, lowpower, deep} to state
  assign pwr_sel = (pwr_bits == 3'b000) ? APR_PWR_NORMAL :
                   (pwr_bits == 3'b001) ? APR_PWR_DEEP :
                   (pwr_bits == 3'b010) ? APR_PWR_LOW :
                   (pwr_bits == 3'b100) ? APR_PWR_SUSPEND : APR_PWR_ILLEGAL;
endmodule
`default_nettype wire

// File: rtl/apr_regs.sv
// wishbone register bank for accel range, bandwidth and power configuration
// Functional notes
// - range codes 0011b, 0101b, 1000b, 1100b select 2g, 4g, 8g and 16g full scale.
// - bandwidth codes 01000b to 01111b map to 7.81 Hz up to 1000 Hz in order.
// - codes 00xxxb act as 7.81 Hz and codes 1xxxxb act as 1000 Hz.
// - suspend, low-power and deep bits select normal, deep, low, suspend, else illegal.
// - with the variant bit zero, suspend and low power use the lean setup: no fifo, slow writes.
// - with the variant bit one, fifo stays accessible and writes run at full speed.
// - in low power the time-base bit picks event-driven (0) or equidistant (1) sampling.
// - equally spaced fifo entry is promised whenever the time-base bit is one, in any power state.
`timescale 1ns/1ps
`default_nettype none
module apr_regs
  import apr_pkg::*;
(
  input wire logic clock, // 200 MHz clock
  input wire logic rst, // async reset, high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic wb_err_o, // unmapped access
  output apr_pkg::apr_fs_t full_scale, // active full scale
  output logic [2:0] band_index, // active bandwidth index
  output apr_pkg::apr_pwr_t power_state, // active power state
  output logic [3:0] sleep_period, // low-power sleep code
  output logic full_access_variant, // variant with fifo kept
  output logic lean_variant, // lean variant active now
  output logic fifo_access_ok, // fifo reachable
  output logic equidistant_sampling, // equidistant time base active
  output logic sample_spacing_even // fifo entry spacing guaranteed
);
  import apr_pkg::*;
  logic [7:0] full_scale_reg;
  logic [7:0] bandwidth_reg;
  logic [7:0] power_reg;
  logic [7:0] low_power_reg;
  logic [7:0] pace_count;
  logic deep_seen;
  apr_fs_t dec_fs;
  logic [2:0] dec_bw;
  apr_pwr_t dec_pwr;

  // decode of byte address into register index
  function automatic logic [1:0] reg_slot(input logic [7:0] adr);
    return adr[3:2] - 2'd3;
  endfunction

  wire logic [5:0] word_idx = wb_adr_i[7:2];
  wire logic addr_hit = (wb_adr_i[1:0] == 2'b00) &&
                        (word_idx >= IDX_FULL_SCALE[5:0]) && (word_idx <= IDX_LOW_POWER[5:0]);
  wire logic [1:0] slot = reg_slot(wb_adr_i);
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic lean_now = !low_power_reg[POS_VARIANT] &&
                        (dec_pwr == APR_PWR_LOW || dec_pwr == APR_PWR_SUSPEND);
  // writes stall while lean pacing runs
  wire logic pace_busy = lean_now && (pace_count != 8'h00);
  wire logic wr_go = req && wb_we_i && addr_hit && wb_sel_i[0] && !pace_busy;
  wire logic rd_go = req && !wb_we_i && addr_hit;
  wire logic wr_nosel = req && wb_we_i && addr_hit && !wb_sel_i[0];
  wire logic bad_go = req && !addr_hit;
  wire logic [7:0] wbyte = wb_dat_i[7:0];
  wire logic leave_deep = deep_seen && (dec_pwr != APR_PWR_DEEP);
  wire logic [7:0] next_power = wbyte & MASK_POWER_STATE;
  wire logic [7:0] rd_byte = (slot == 2'd0) ? full_scale_reg :
                             (slot == 2'd1) ? bandwidth_reg :
                             (slot == 2'd2) ? power_reg : low_power_reg;

  apr_decode u_decode (
    .full_scale_reg(full_scale_reg),
    .bandwidth_reg(bandwidth_reg),
    .power_reg(power_reg),
    .fs_sel(dec_fs),
    .bw_index(dec_bw),
    .pwr_sel(dec_pwr)
  );

  // register storage; leaving deep suspend restores defaults
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      full_scale_reg <= RST_FULL_SCALE;
      bandwidth_reg <= RST_BANDWIDTH;
      power_reg <= RST_POWER_STATE;
      low_power_reg <= RST_LOW_POWER;
    end else if (wr_go) begin
      unique case (slot)
        2'd0: full_scale_reg <= wbyte & MASK_FULL_SCALE;
        2'd1: bandwidth_reg <= wbyte & MASK_BANDWIDTH;
        2'd2: power_reg <= next_power;
        2'd3: low_power_reg <= wbyte & MASK_LOW_POWER;
      endcase
    end else if (leave_deep) begin
      full_scale_reg <= RST_FULL_SCALE;
      bandwidth_reg <= RST_BANDWIDTH;
      low_power_reg <= RST_LOW_POWER;
    end
  end

  // tracks deep suspend to spot its exit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      deep_seen <= 1'b0;
    end else begin
      deep_seen <= (dec_pwr == APR_PWR_DEEP);
    end
  end

  // lean variant write gap counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pace_count <= 8'h00;
    end else if (wr_go && lean_now) begin
      pace_count <= 8'(LEAN_WRITE_GAP_CYC);
    end else if (pace_count != 8'h00) begin
      pace_count <= pace_count - 8'h01;
    end
  end

  // bus answer, one cycle after request, or for a write held by lean pacing one cycle after pace_count reaches zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wr_go || rd_go || wr_nosel;
      wb_err_o <= bad_go;
      wb_dat_o <= rd_go ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // registered configuration outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      full_scale <= APR_FS_2G;
      band_index <= 3'h7;
      power_state <= APR_PWR_NORMAL;
      sleep_period <= 4'h0;
      full_access_variant <= 1'b0;
      lean_variant <= 1'b0;
      fifo_access_ok <= 1'b1;
      equidistant_sampling <= 1'b0;
      sample_spacing_even <= 1'b0;
    end else begin
      full_scale <= dec_fs;
      band_index <= dec_bw;
      power_state <= dec_pwr;
      sleep_period <= power_reg[POS_SLEEP_LSB +: 4];
      full_access_variant <= low_power_reg[POS_VARIANT];
      lean_variant <= lean_now;
      fifo_access_ok <= !lean_now;
      equidistant_sampling <= (dec_pwr == APR_PWR_LOW) && low_power_reg[POS_TIMEBASE];
      sample_spacing_even <= low_power_reg[POS_TIMEBASE];
    end
  end

  // read answer follows a read request by one cycle
  chk_ack_timing: assert property (@(posedge clock) disable iff (rst)
    (wb_cyc_i && wb_stb_i && !wb_we_i && addr_hit && !wb_ack_o && !wb_err_o) |=> wb_ack_o)
    else $error("read not acknowledged in one cycle");
  chk_range_decode: assert property (@(posedge clock) disable iff (rst)
    (full_scale_reg[3:0] == RANGE_16G) |=> (full_scale == APR_FS_16G))
    else $error("16g code not decoded");
  chk_band_clamp_hi: assert property (@(posedge clock) disable iff (rst)
    bandwidth_reg[4] |=> (band_index == 3'h7))
    else $error("top bandwidth clamp failed");
  chk_band_map: assert property (@(posedge clock) disable iff (rst)
    (bandwidth_reg[4:3] == 2'b01) |=> (band_index == $past(bandwidth_reg[2:0])))
    else $error("bandwidth map wrong");
  chk_power_deep: assert property (@(posedge clock) disable iff (rst)
    (power_reg[7:5] == 3'b001) |=> (power_state == APR_PWR_DEEP))
    else $error("deep suspend not selected");
  chk_lean_pace: assert property (@(posedge clock) disable iff (rst)
    (wr_go && lean_now) |=> (pace_count == 8'(LEAN_WRITE_GAP_CYC)))
    else $error("lean write not paced");
  chk_full_speed: assert property (@(posedge clock) disable iff (rst)
    (req && wb_we_i && addr_hit && wb_sel_i[0] && low_power_reg[POS_VARIANT]) |=> wb_ack_o)
    else $error("full access variant stalled");
  chk_timebase_sel: assert property (@(posedge clock) disable iff (rst)
    ((dec_pwr == APR_PWR_LOW) && !low_power_reg[POS_TIMEBASE]) |=> !equidistant_sampling)
    else $error("event time base not kept");
  chk_deep_restore: assert property (@(posedge clock) disable iff (rst)
    (leave_deep && !wr_go) |=> (bandwidth_reg == RST_BANDWIDTH))
    else $error("settings kept after deep suspend");
  chk_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    ((full_scale_reg & ~MASK_FULL_SCALE) == 8'h00) &&
    ((bandwidth_reg & ~MASK_BANDWIDTH) == 8'h00))
    else $error("reserved bit stored");
  chk_reserved_pwr: assert property (@(posedge clock) disable iff (rst)
    ((power_reg & ~MASK_POWER_STATE) == 8'h00) &&
    ((low_power_reg & ~MASK_LOW_POWER) == 8'h00))
    else $error("reserved power bit stored");

  // bus answer shape and refused accesses
  chk_ack_pulse: assert property (@(posedge clock) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_err_pulse: assert property (@(posedge clock) disable iff (rst)
    wb_err_o |=> !wb_err_o)
    else $error("err held longer than one cycle");
  chk_ack_err_excl: assert property (@(posedge clock) disable iff (rst)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  chk_dat_idle: assert property (@(posedge clock) disable iff (rst)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data outside an answer");
  chk_err_answer: assert property (@(posedge clock) disable iff (rst)
    (wb_cyc_i && wb_stb_i && !addr_hit && !wb_ack_o && !wb_err_o) |=> wb_err_o)
    else $error("unmapped access not refused");
  chk_read_data: assert property (@(posedge clock) disable iff (rst)
    rd_go |=> (wb_dat_o == {24'h00_0000, $past(rd_byte)}))
    else $error("read data wrong");
  chk_write_ack: assert property (@(posedge clock) disable iff (rst)
    wr_go |=> wb_ack_o)
    else $error("taken write not acknowledged");

  // writes that must or must not land
  chk_nosel_kept: assert property (@(posedge clock) disable iff (rst)
    (wr_nosel && !leave_deep) |=> ($stable(full_scale_reg) && $stable(power_reg)))
    else $error("unselected write changed a register");
  chk_err_kept: assert property (@(posedge clock) disable iff (rst)
    (bad_go && !leave_deep) |=> ($stable(bandwidth_reg) && $stable(low_power_reg)))
    else $error("refused access changed a register");
  chk_write_lands: assert property (@(posedge clock) disable iff (rst)
    (wr_go && (slot == 2'd1)) |=> (bandwidth_reg == ($past(wbyte) & MASK_BANDWIDTH)))
    else $error("bandwidth write lost");

  // decode of stored settings into outputs
  chk_range_2g: assert property (@(posedge clock) disable iff (rst)
    (full_scale_reg[3:0] == RANGE_2G) |=> (full_scale == APR_FS_2G))
    else $error("2g code not decoded");
  chk_range_4g: assert property (@(posedge clock) disable iff (rst)
    (full_scale_reg[3:0] == RANGE_4G) |=> (full_scale == APR_FS_4G))
    else $error("4g code not decoded");
  chk_range_8g: assert property (@(posedge clock) disable iff (rst)
    (full_scale_reg[3:0] == RANGE_8G) |=> (full_scale == APR_FS_8G))
    else $error("8g code not decoded");
  chk_range_rsvd: assert property (@(posedge clock) disable iff (rst)
    (full_scale_reg[3:0] == 4'h0) |=> (full_scale == APR_FS_RSVD))
    else $error("reserved range code not flagged");
  chk_band_clamp_lo: assert property (@(posedge clock) disable iff (rst)
    (bandwidth_reg[4:3] == 2'b00) |=> (band_index == 3'h0))
    else $error("bottom bandwidth clamp failed");
  chk_band_top_code: assert property (@(posedge clock) disable iff (rst)
    (bandwidth_reg[4:0] == BW_HIGH_CODE) |=> (band_index == 3'h7))
    else $error("top bandwidth code wrong");
  chk_power_normal: assert property (@(posedge clock) disable iff (rst)
    (power_reg[7:5] == 3'b000) |=> (power_state == APR_PWR_NORMAL))
    else $error("normal state not selected");
  chk_power_low: assert property (@(posedge clock) disable iff (rst)
    (power_reg[7:5] == 3'b010) |=> (power_state == APR_PWR_LOW))
    else $error("low power not selected");
  chk_power_suspend: assert property (@(posedge clock) disable iff (rst)
    (power_reg[7:5] == 3'b100) |=> (power_state == APR_PWR_SUSPEND))
    else $error("suspend not selected");
  chk_power_illegal: assert property (@(posedge clock) disable iff (rst)
    (power_reg[7:5] == 3'b111) |=> (power_state == APR_PWR_ILLEGAL))
    else $error("illegal power bits not flagged");
  chk_sleep_field: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (sleep_period == $past(power_reg[4:1])))
    else $error("sleep period not passed on");

  // variant, time base, pacing and deep-suspend restore
  chk_fifo_inverse: assert property (@(posedge clock) disable iff (rst)
    (fifo_access_ok != lean_variant))
    else $error("fifo access and lean variant agree");
  chk_lean_suspend: assert property (@(posedge clock) disable iff (rst)
    (!low_power_reg[POS_VARIANT] && (dec_pwr == APR_PWR_SUSPEND)) |=> !fifo_access_ok)
    else $error("fifo reachable in lean suspend");
  chk_lean_low: assert property (@(posedge clock) disable iff (rst)
    (!low_power_reg[POS_VARIANT] && (dec_pwr == APR_PWR_LOW)) |=> lean_variant)
    else $error("lean variant missing in low power");
  chk_normal_full: assert property (@(posedge clock) disable iff (rst)
    (dec_pwr == APR_PWR_NORMAL) |=> (!lean_variant && fifo_access_ok))
    else $error("lean variant outside low power states");
  chk_full_fifo: assert property (@(posedge clock) disable iff (rst)
    low_power_reg[POS_VARIANT] |=> fifo_access_ok)
    else $error("fifo blocked in full access variant");
  chk_variant_follow: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (full_access_variant == $past(low_power_reg[POS_VARIANT])))
    else $error("variant output wrong");
  chk_equidistant_on: assert property (@(posedge clock) disable iff (rst)
    ((dec_pwr == APR_PWR_LOW) && low_power_reg[POS_TIMEBASE]) |=> equidistant_sampling)
    else $error("equidistant time base not used");
  chk_event_outside: assert property (@(posedge clock) disable iff (rst)
    (dec_pwr != APR_PWR_LOW) |=> !equidistant_sampling)
    else $error("time base active outside low power");
  chk_spacing_follow: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> (sample_spacing_even == $past(low_power_reg[POS_TIMEBASE])))
    else $error("spacing promise wrong");
  chk_pace_count: assert property (@(posedge clock) disable iff (rst)
    (pace_count != 8'h00 && !(wr_go && lean_now)) |=> (pace_count == $past(pace_count) - 8'h01))
    else $error("pace counter not counting down");
  chk_deep_restore_all: assert property (@(posedge clock) disable iff (rst)
    (leave_deep && !wr_go) |=>
    ((full_scale_reg == RST_FULL_SCALE) && (low_power_reg == RST_LOW_POWER)))
    else $error("range or low power kept after deep suspend");
endmodule
`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the accel power/range register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import apr_pkg::*;
  logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, e;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, sleep_period;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  apr_fs_t full_scale;
  apr_pwr_t power_state;
  logic [2:0] band_index;
  logic full_access_variant, lean_variant, fifo_access_ok, equidistant_sampling;
  logic sample_spacing_even;
  int n_fail, total_checks, seed, lat, k;
  logic [7:0] m [4];
  logic [7:0] msk [4] = '{MASK_FULL_SCALE, MASK_BANDWIDTH, MASK_POWER_STATE, MASK_LOW_POWER};
  logic [7:0] rstv [4] = '{RST_FULL_SCALE, RST_BANDWIDTH, RST_POWER_STATE, RST_LOW_POWER};
  logic [7:0] adr [4] = '{{IDX_FULL_SCALE[5:0], 2'b00}, {IDX_BANDWIDTH[5:0], 2'b00},
    {IDX_POWER_STATE[5:0], 2'b00}, {IDX_LOW_POWER[5:0], 2'b00}};
  apr_regs i_dut (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .full_scale(full_scale),
    .band_index(band_index), .power_state(power_state), .sleep_period(sleep_period),
    .full_access_variant(full_access_variant), .lean_variant(lean_variant),
    .fifo_access_ok(fifo_access_ok), .equidistant_sampling(equidistant_sampling),
    .sample_spacing_even(sample_spacing_even));
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // expected decodes
  function automatic apr_fs_t exp_fs(input logic [3:0] c);
    case (c)
      RANGE_2G: return APR_FS_2G;
      RANGE_4G: return APR_FS_4G;
      RANGE_8G: return APR_FS_8G;
      RANGE_16G: return APR_FS_16G;
      default: return APR_FS_RSVD;
    endcase
  endfunction
  function automatic logic [2:0] exp_bw(input logic [4:0] c);
    return c[4] ? 3'h7 : (c[3] ? c[2:0] : 3'h0);
  endfunction
  function automatic apr_pwr_t exp_pwr(input logic [2:0] b);
    case (b)
      3'b000: return APR_PWR_NORMAL;
      3'b001: return APR_PWR_DEEP;
      3'b010: return APR_PWR_LOW;
      3'b100: return APR_PWR_SUSPEND;
      default: return APR_PWR_ILLEGAL;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // one classic wishbone cycle, held until ack or err is sampled
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] sel, output logic [31:0] rq, output logic re, output int n);
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel;
    wb_dat_i <= {8'(seed), 16'h5AA5, d};
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 200);
    check({31'h0, wb_ack_o | wb_err_o}, 32'h1, "bus answer");
    rq = wb_dat_o;
    re = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // compare every decoded output with the register model
  task automatic chk_out();
    logic lean;
    apr_pwr_t p;
    p = exp_pwr(m[2][7:5]);
    lean = (p == APR_PWR_LOW || p == APR_PWR_SUSPEND) && !m[3][6];
    @(posedge clock);
    #1;
    check(full_scale, exp_fs(m[0][3:0]), "full scale");
    check(band_index, exp_bw(m[1][4:0]), "band index");
    check(power_state, p, "power state");
    check(sleep_period, m[2][4:1], "sleep period");
    check(full_access_variant, m[3][6], "full access");
    check(lean_variant, lean, "lean variant");
    check(fifo_access_ok, !lean, "fifo access");
    check(equidistant_sampling, p == APR_PWR_LOW && m[3][5], "equidistant");
    check(sample_spacing_even, m[3][5], "spacing even");
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    logic was_deep;
    was_deep = exp_pwr(m[2][7:5]) == APR_PWR_DEEP;
    wb_xfer(1'b1, adr[i], d, 4'h1 | 4'($random(seed)), q, e, lat);
    check(e, 1'b0, "write refused");
    m[i] = d & msk[i];
    if (i == 2 && was_deep && exp_pwr(d[7:5]) != APR_PWR_DEEP) begin
      m[0] = rstv[0];
      m[1] = rstv[1];
      m[3] = rstv[3];
    end
    chk_out();
  endtask
  task automatic rd(input int i);
    wb_xfer(1'b0, adr[i], 8'h00, 4'h1, q, e, lat);
    check(q, {24'h0, m[i]}, "read back");
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    report_and_stop();
  end
  // main sequence
  initial begin
    seed = 32'h7961;
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    rst = 1'b1;
    for (int i = 0; i < 4; i++) m[i] = rstv[i];
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(i);
    chk_out();
    for (int c = 0; c < 16; c++) begin
      wr(0, (8'($random(seed)) & 8'hF0) | 8'(c));
      rd(0);
    end
    for (int c = 0; c < 32; c++) begin
      wr(1, (8'($random(seed)) & 8'hE0) | 8'(c));
      rd(1);
    end
    for (int c = 0; c < 8; c++) begin
      wr(2, {3'(c), 5'($random(seed))});
      rd(2);
    end
    // host-side use of the four defined range codes only
    wr(0, {4'h0, RANGE_2G});
    wr(0, {4'h0, RANGE_4G});
    wr(0, {4'h0, RANGE_8G});
    wr(0, {4'h0, RANGE_16G});
    rd(0);
    // deep suspend drops the other settings
    wr(2, 8'h00);
    wr(0, {4'h0, RANGE_16G});
    wr(1, 8'h0A);
    wr(2, 8'h20);
    wr(2, 8'h00);
    rd(0);
    rd(1);
    // lean and full-access variants in low power
    wr(2, 8'h40);
    wr(3, 8'h00);
    wr(3, 8'h00);
    check(lat > 2, 1'b1, "lean write paced");
    wr(3, 8'hFF);
    wr(3, 8'hC0);
    check(lat == 2, 1'b1, "full speed write");
    wr(3, 8'h20);
    wr(2, 8'h80);
    wr(2, 8'h00);
    // unmapped, misaligned and unselected accesses
    wb_xfer(1'b1, 8'h4C, 8'hFF, 4'h1, q, e, lat);
    check(e, 1'b1, "unmapped write");
    wb_xfer(1'b0, 8'h3D, 8'h00, 4'h1, q, e, lat);
    check(e, 1'b1, "misaligned read");
    wb_xfer(1'b1, adr[0], 8'h05, 4'hE, q, e, lat);
    check(e, 1'b0, "unselected write");
    rd(0);
    // reset in mid-run brings every default back
    rst <= 1'b1;
    for (int i = 0; i < 4; i++) m[i] = rstv[i];
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(i);
    chk_out();
    // random traffic over all registers
    repeat (60) begin
      k = {$random(seed)} % 4;
      wr(k, 8'($random(seed)));
      rd(k);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
